// file: bench/fbc_flash_model.sv
// Behavioural byte-mode flash device facing the host controller
`timescale 1ns/1ps
module fbc_flash_model #(
	parameter logic [7:0] ID_M = 8'h5C, // Arbitrary value
	parameter logic [7:0] ID_D = 8'hA3, // Arbitrary value
	parameter logic [7:0] SEC_ST = 8'h80
) (
	input wire logic [22:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_ce_n,
	input wire logic flash_we_n,
	input wire logic flash_oe_n,
	output logic [15:0] flash_dq_in
);
	logic [22:0] la[$];
	logic [15:0] ld[$];
	logic [7:0] mem [logic [22:0]];
	logic [22:0] pa = 23'h00_0000;
	logic [15:0] held = 16'h0000;
	logic [7:0] d;
	logic [1:0] unl = 2'd0;
	logic auto = 1'b0;
	logic sec = 1'b0;
	logic prot = 1'b0;
	logic prog = 1'b0;
	logic p90 = 1'b0;
	wire wstb = flash_ce_n | flash_we_n;

	// Read view depends on the command mode that was entered
	function automatic logic [7:0] rdv(input logic [22:0] a);
		if (auto) begin
			case (a[7:0])
				8'h00: return ID_M;
				8'h02: return ID_D;
				8'h04: return 8'h01;
				8'h06: return SEC_ST;
				default: return 8'h00;
			endcase
		end
		if (prot)
			return 8'h00;
		if (sec)
			return SEC_ST ^ a[7:0];
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction

	// Address taken when the later of the two strobes falls
	always @(negedge wstb) pa = flash_addr;

	// Data and command decode when the earlier strobe rises; upper byte ignored
	always @(posedge wstb) begin
		d = flash_dq_out[7:0];
		la.push_back(pa);
		ld.push_back(flash_dq_out);
		if (prog) begin
			mem[pa] = d;
			prog = 1'b0;
		end else if (d == 8'hF0)
			{auto, sec, prot} = 3'b000;
		else if (p90 && d == 8'h00)
			{auto, sec, prot} = 3'b000;
		else if (d == 8'hA0)
			prog = 1'b1;
		else if (unl == 2'd2) begin
			auto = auto | (d == 8'h90);
			sec = sec | (d == 8'h88);
			prot = prot | (d inside {8'h40, 8'h50, 8'h60, 8'hC0, 8'hE0});
		end
		p90 = (d == 8'h90);
		if (d == 8'hAA && pa[11:0] == 12'hAAA)
			unl = 2'd1;
		else if (unl == 2'd1 && d == 8'h55 && pa[11:0] == 12'h555)
			unl = 2'd2;
		else
			unl = 2'd0;
	end

	// Released bus shows the inverse of the last value so stale data never passes
	always @(negedge flash_oe_n) held = {8'h00, rdv(flash_addr)};
	always @* begin
		if (!flash_ce_n && !flash_oe_n)
			flash_dq_in = {8'h00, rdv(flash_addr)};
		else
			flash_dq_in = ~held;
	end
endmodule

// file: bench/testbench.sv
// Register-level tests of the flash host controller against the device model
`timescale 1ns/1ps
`include "fbc_cfg.svh"
module testbench;
	localparam logic [22:0] A1 = 23'h00_0AAA;
	localparam logic [22:0] SA = 23'h01_0000;
	localparam logic [7:0] ID_M = 8'h5C; // Arbitrary value
	localparam logic [7:0] ID_D = 8'hA3; // Arbitrary value
	localparam logic [7:0] SEC_ST = 8'h80;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] sv;
	logic [22:0] flash_addr;
	logic [15:0] flash_dq_in;
	logic [15:0] flash_dq_out;
	logic flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n, accelerate_pin, flash_dq_oe;
	logic [15:0] pw [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
	int fail_count = 0;
	int samples_checked = 0;

	always #5 clock = ~clock;

	fbc_host u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.flash_addr(flash_addr), .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n), .flash_byte_n(flash_byte_n), .accelerate_pin(accelerate_pin));
	fbc_flash_model #(.ID_M(ID_M), .ID_D(ID_D), .SEC_ST(SEC_ST)) u_flash (
		.flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in));

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Strobe is dropped a full cycle before the next access may raise it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 sv = reg_rdata;
		@(posedge clock);
	endtask
	// Issue one operation and wait, bounded, until busy drops
	task automatic op(input logic [4:0] o, input logic [22:0] a, input logic [15:0] d);
		int n;
		u_flash.la.delete();
		u_flash.ld.delete();
		wr(`FBC_REG_ADDR, {9'h000, a});
		wr(`FBC_REG_WDATA, {16'h0000, d});
		wr(`FBC_REG_CMD, {27'h000_0000, o});
		n = 0;
		rd(`FBC_REG_STATUS);
		while (sv[`FBC_ST_BUSY] !== 1'b0 && n < 300) begin
			rd(`FBC_REG_STATUS);
			n++;
		end
		chk(32'(n == 300), 32'h0000_0000);
	endtask
	task automatic exw(input logic [22:0] a, input logic [15:0] d);
		chk({9'h000, u_flash.la.pop_front()}, {9'h000, a});
		chk({16'h0000, u_flash.ld.pop_front()}, {16'h0000, d});
	endtask
	task automatic unlk();
		exw(A1, 16'h00AA);
		exw(23'h00_0555, 16'h0055);
	endtask
	task automatic st(input int b, input logic e);
		rd(`FBC_REG_STATUS);
		chk({31'h0000_0000, sv[b]}, {31'h0000_0000, e});
	endtask
	task automatic rdd(input logic [31:0] e);
		rd(`FBC_REG_RDATA);
		chk(sv, e);
	endtask
	task automatic tend(input string nm);
		chk(32'(u_flash.la.size()), 32'h0000_0000);
		$display("test %s done", nm);
	endtask

	// Watchdog well beyond the expected run of a few tens of microseconds
	initial begin
		#500_000;
		fail_count++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		// Strobes idle high, byte mode, pins released after reset
		chk({flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n, accelerate_pin, flash_dq_oe},
			32'h0000_0038);
		// Program then plain array read
		op(5'h05, 23'h00_0123, 16'h005A);
		unlk();
		exw(A1, 16'h00A0);
		exw(23'h00_0123, 16'h005A);
		op(5'h00, 23'h00_0123, 16'h0000);
		rdd(32'h0000_005A);
		tend("program");
		// Identity reads, sector verify, then reset back to the array
		op(5'h02, 23'h00_0000, 16'h0000);
		unlk();
		exw(A1, 16'h0090);
		rdd({24'h00_0000, ID_M});
		op(5'h02, 23'h00_0002, 16'h0000);
		rdd({24'h00_0000, ID_D});
		op(5'h02, 23'h00_0006, 16'h0000);
		rdd({24'h00_0000, SEC_ST});
		op(5'h02, SA | 23'h00_0004, 16'h0000);
		rdd(32'h0000_0001);
		op(5'h01, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h00F0);
		op(5'h00, 23'h00_0123, 16'h0000);
		rdd(32'h0000_005A);
		tend("autoselect");
		// Secured region entry and exit
		op(5'h03, 23'h00_0000, 16'h0000);
		unlk();
		exw(A1, 16'h0088);
		op(5'h00, 23'h00_0005, 16'h0000);
		rdd({24'h00_0000, SEC_ST ^ 8'h05});
		op(5'h04, 23'h00_0000, 16'h0000);
		unlk();
		exw(A1, 16'h0090);
		exw(23'h00_0000, 16'h0000);
		op(5'h00, 23'h00_0123, 16'h0000);
		rdd(32'h0000_005A);
		tend("secured");
		// Buffer load to the longest sequence, commit, then abort
		op(5'h08, SA, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h06, SA, 16'h001F);
		st(`FBC_ST_BUF, 1'b1);
		unlk();
		exw(SA, 16'h0025);
		exw(SA, 16'h001F);
		for (int i = 0; i < 33; i++) begin
			op(5'h07, SA + 23'(i), 16'(i));
			st(`FBC_ST_REFUSED, i == 32);
			if (i < 32)
				exw(SA + 23'(i), 16'(i));
		end
		op(5'h08, SA, 16'h0000);
		exw(SA, 16'h0029);
		op(5'h06, SA, 16'h0000);
		op(5'h09, 23'h00_0000, 16'h0000);
		unlk();
		exw(A1, 16'h00F0);
		op(5'h07, SA, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		tend("buffer");
		// Erase, suspend and resume gating
		op(5'h0F, 23'h00_0000, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h0B, SA, 16'h0000);
		unlk();
		exw(A1, 16'h0080);
		unlk();
		exw(SA, 16'h0030);
		st(`FBC_ST_ERASE, 1'b1);
		op(5'h0F, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h00B0);
		st(`FBC_ST_SUSP, 1'b1);
		op(5'h0F, 23'h00_0000, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h10, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h0030);
		op(5'h10, 23'h00_0000, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h0A, 23'h00_0000, 16'h0000);
		unlk();
		exw(A1, 16'h0080);
		unlk();
		exw(A1, 16'h0010);
		op(5'h01, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h00F0);
		st(`FBC_ST_ERASE, 1'b0);
		tend("erase");
		// Protection mode: gating, indicator, all-bit erase, exit
		op(5'h13, SA, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h17, SA, 16'h0000);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h12, 23'h00_0000, 16'h00C0);
		unlk();
		exw(A1, 16'h00C0);
		st(`FBC_ST_PROT, 1'b1);
		chk({31'h0000_0000, accelerate_pin}, 32'h0000_0001);
		op(5'h17, SA, 16'h0000);
		st(`FBC_ST_PROTECTED, 1'b1);
		op(5'h15, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h0080);
		exw(23'h00_0000, 16'h0030);
		op(5'h12, 23'h00_0000, 16'h00C0);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h14, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h0090);
		exw(23'h00_0000, 16'h0000);
		st(`FBC_ST_PROT, 1'b0);
		chk({31'h0000_0000, accelerate_pin}, 32'h0000_0000);
		op(5'h00, 23'h00_0777, 16'h0000);
		st(`FBC_ST_PROTECTED, 1'b0);
		tend("protect");
		// One password portion programmed, then all portions unlocked
		wr(`FBC_REG_PWD_LO, 32'h2222_1111);
		wr(`FBC_REG_PWD_HI, 32'h4444_3333);
		op(5'h12, 23'h00_0000, 16'h0060);
		op(5'h13, 23'h00_0001, 16'h2222);
		exw(23'h00_0000, 16'h00A0);
		exw(23'h00_0001, 16'h2222);
		op(5'h16, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h0025);
		exw(23'h00_0000, 16'h0003);
		for (int i = 0; i < 4; i++)
			exw(23'(i), pw[i]);
		exw(23'h00_0000, 16'h0029);
		op(5'h14, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h0090);
		exw(23'h00_0000, 16'h0000);
		tend("password");
		// Bypass programming
		op(5'h0D, 23'h00_0200, 16'h003C);
		st(`FBC_ST_REFUSED, 1'b1);
		op(5'h0C, 23'h00_0000, 16'h0000);
		unlk();
		exw(A1, 16'h0020);
		st(`FBC_ST_BYPASS, 1'b1);
		op(5'h0D, 23'h00_0200, 16'h003C);
		exw(23'h00_0000, 16'h00A0);
		exw(23'h00_0200, 16'h003C);
		op(5'h0E, 23'h00_0000, 16'h0000);
		exw(23'h00_0000, 16'h0090);
		exw(23'h00_0000, 16'h0000);
		op(5'h00, 23'h00_0200, 16'h0000);
		rdd(32'h0000_003C);
		tend("bypass");
		// Query and an unmapped register
		op(5'h11, 23'h00_0000, 16'h0000);
		exw(23'h00_00AA, 16'h0098);
		rd(8'h40);
		chk(sv, 32'h0000_0000);
		tend("query");
		end_sim();
	end
endmodule

// file: rtl/fbc_bus_cycle.sv
// One asynchronous flash bus cycle: address setup, strobe pulse, hold
`timescale 1ns/1ps
`include "fbc_cfg.svh"
module fbc_bus_cycle (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire fbc_pkg::fbc_cycle_s cyc,
	output logic done,
	output logic [15:0] rdata_q,
	output logic [22:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n
);
	fbc_pkg::fbc_cyc_state_e state_q, state_d;
	fbc_pkg::fbc_cycle_s cyc_q, cyc_d;
	logic [3:0] cnt_q, cnt_d;
	logic [15:0] rdata_d;
	logic [15:0] flash_dq_in_unused;

	assign flash_dq_in_unused = 16'h0000;

	// Next state: address is set one cycle before the strobes fall
	always_comb begin
		state_d = state_q;
		cyc_d = cyc_q;
		cnt_d = cnt_q;
		rdata_d = rdata_q;
		done = 1'b0;
		unique case (state_q)
			fbc_pkg::CYC_IDLE: begin
				if (start) begin
					cyc_d = cyc;
					state_d = fbc_pkg::CYC_SETUP;
				end
			end
			fbc_pkg::CYC_SETUP: begin
				cnt_d = 4'(`FBC_PULSE_CYC - 1);
				state_d = fbc_pkg::CYC_PULSE;
			end
			fbc_pkg::CYC_PULSE: begin
				if (cnt_q == 4'h0) begin
					state_d = fbc_pkg::CYC_HOLD;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			fbc_pkg::CYC_HOLD: begin
				done = 1'b1;
				state_d = fbc_pkg::CYC_IDLE;
			end
		endcase
	end

	// Registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= fbc_pkg::CYC_IDLE;
			cyc_q <= '0;
			cnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			cyc_q <= cyc_d;
			cnt_q <= cnt_d;
		end
	end

	// Read data is taken by the main module from the pins; kept here at zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d | flash_dq_in_unused;
		end
	end

	// Address held over setup, pulse and hold so it is stable at both strobe
	// edges whichever of chip enable or write strobe falls later
	assign flash_addr = cyc_q.addr;
	// Data bits are driven as the cycle supplies them, upper byte included
	assign flash_dq_out = cyc_q.data;
	assign flash_dq_oe = !cyc_q.rd && (state_q != fbc_pkg::CYC_IDLE);
	assign flash_ce_n = (state_q != fbc_pkg::CYC_PULSE);
	assign flash_we_n = !((state_q == fbc_pkg::CYC_PULSE) && !cyc_q.rd);
	assign flash_oe_n = !((state_q == fbc_pkg::CYC_PULSE) && cyc_q.rd);
endmodule

// file: rtl/fbc_cfg.svh
// Offsets, command codes and timing counts for the flash bus controller
`ifndef FBC_CFG_SVH
`define FBC_CFG_SVH

`define FBC_AW 23
`define FBC_DW 16
// Software register byte offsets
`define FBC_REG_CMD 8'h00
`define FBC_REG_ADDR 8'h04
`define FBC_REG_WDATA 8'h08
`define FBC_REG_PWD_LO 8'h0C
`define FBC_REG_PWD_HI 8'h10
`define FBC_REG_STATUS 8'h14
`define FBC_REG_RDATA 8'h18
// Status field positions
`define FBC_ST_BUSY 0
`define FBC_ST_REFUSED 1
`define FBC_ST_PROT 2
`define FBC_ST_BYPASS 3
`define FBC_ST_BUF 4
`define FBC_ST_ERASE 5
`define FBC_ST_SUSP 6
`define FBC_ST_PROTECTED 7
// Operation codes written to the command register
`define FBC_OP_READ 5'h00
`define FBC_OP_RESET 5'h01
`define FBC_OP_AUTOSEL 5'h02
`define FBC_OP_SEC_ENTER 5'h03
`define FBC_OP_SEC_EXIT 5'h04
`define FBC_OP_PROGRAM 5'h05
`define FBC_OP_BUF_START 5'h06
`define FBC_OP_BUF_WORD 5'h07
`define FBC_OP_BUF_COMMIT 5'h08
`define FBC_OP_ABORT_RST 5'h09
`define FBC_OP_CHIP_ERASE 5'h0A
`define FBC_OP_SECT_ERASE 5'h0B
`define FBC_OP_BYP_ENTER 5'h0C
`define FBC_OP_BYP_PROG 5'h0D
`define FBC_OP_BYP_RESET 5'h0E
`define FBC_OP_SUSPEND 5'h0F
`define FBC_OP_RESUME 5'h10
`define FBC_OP_QUERY 5'h11
`define FBC_OP_PROT_ENTER 5'h12
`define FBC_OP_PROT_PROG 5'h13
`define FBC_OP_PROT_EXIT 5'h14
`define FBC_OP_PPB_ERASE 5'h15
`define FBC_OP_PWD_UNLOCK 5'h16
`define FBC_OP_PROT_READ 5'h17
// Flash command addresses and data
`define FBC_A_UNLOCK1 23'h00_0AAA
`define FBC_A_UNLOCK2 23'h00_0555
`define FBC_A_QUERY 23'h00_00AA
`define FBC_D_UNLOCK1 16'h00AA
`define FBC_D_UNLOCK2 16'h0055
`define FBC_D_RESET 16'h00F0
`define FBC_D_AUTOSEL 16'h0090
`define FBC_D_SECURE 16'h0088
`define FBC_D_ZERO 16'h0000
`define FBC_D_PROGRAM 16'h00A0
`define FBC_D_BUF_LOAD 16'h0025
`define FBC_D_BUF_COMMIT 16'h0029
`define FBC_D_ERASE 16'h0080
`define FBC_D_CHIP 16'h0010
`define FBC_D_SECTOR 16'h0030
`define FBC_D_BYPASS 16'h0020
`define FBC_D_SUSPEND 16'h00B0
`define FBC_D_RESUME 16'h0030
`define FBC_D_QUERY 16'h0098
`define FBC_D_PWD_COUNT 16'h0003
`define FBC_D_PPB_CODE 16'h00C0
`define FBC_D_DYB_CODE 16'h00E0
// Longest byte-mode buffer sequence, commit included
`define FBC_BUF_MAX_CYC 6'd37
// Strobe timing: setup/hold and pulse width
`define FBC_CLK_NS 10
`define FBC_PULSE_NS 40
`define FBC_PULSE_CYC ((`FBC_PULSE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)

`endif

// file: rtl/fbc_host.sv
// Host-side controller issuing byte-mode flash command sequences
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "fbc_cfg.svh"
// Function
// - Unlock writes open each command except read, reset, query, suspend, resume and in-mode ones
// - Reset command restores array reading
// - Exit sequence leaves protection mode
// - Each password portion programmed with two cycles
// - Unlock delivers all portions, seven cycles
// - Accelerate pin high setting protect bits
// - Buffer load: 25, count, then pairs
// - Buffer count equals locations minus one
module fbc_host (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	output logic [22:0] flash_addr,
	input wire logic [15:0] flash_dq_in,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic flash_byte_n,
	output logic accelerate_pin
);
	logic [4:0] op_q, op_d;
	logic [22:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [63:0] pwd_q, pwd_d;
	logic [3:0] idx_q, idx_d;
	logic busy_q, busy_d, refused_q, refused_d, launch_q, launch_d;
	logic prot_q, prot_d, byp_q, byp_d, buf_q, buf_d, erase_q, erase_d, susp_q, susp_d;
	logic [7:0] prot_code_q, prot_code_d;
	logic [5:0] buf_cyc_q, buf_cyc_d;
	logic [31:0] reg_rdata_d;
	logic cmd_wr, allowed, cyc_done;
	logic [4:0] new_op;
	fbc_pkg::fbc_cycle_s cyc;
	logic [15:0] sub_rdata_unused;

	// Build one write cycle
	function automatic fbc_pkg::fbc_cycle_s wr(input logic [22:0] a, input logic [15:0] d,
			input logic last);
		fbc_pkg::fbc_cycle_s c;
		c.addr = a;
		c.data = d;
		c.rd = 1'b0;
		c.last = last;
		return c;
	endfunction

	// Bus cycle for the current operation and step
	always_comb begin
		cyc = wr(`FBC_A_UNLOCK1, `FBC_D_UNLOCK1, 1'b0);
		if (idx_q == 4'h1) begin
			cyc = wr(`FBC_A_UNLOCK2, `FBC_D_UNLOCK2, 1'b0);
		end
		unique case (op_q)
			`FBC_OP_READ, `FBC_OP_PROT_READ: begin
				// Plain read, no unlock needed; password portion picked by addr
				cyc = wr(addr_q, `FBC_D_ZERO, 1'b1);
				cyc.rd = 1'b1;
			end
			`FBC_OP_RESET: cyc = wr(23'h00_0000, `FBC_D_RESET, 1'b1);
			`FBC_OP_AUTOSEL: begin
				if (idx_q == 4'h2) begin
					cyc = wr(`FBC_A_UNLOCK1, `FBC_D_AUTOSEL, 1'b0);
				end else if (idx_q == 4'h3) begin
					// Identity at 00/02/06, sector protection at sector+04
					cyc = wr(addr_q, `FBC_D_ZERO, 1'b1);
					cyc.rd = 1'b1;
				end
			end
			`FBC_OP_SEC_ENTER: begin
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, `FBC_D_SECURE, 1'b1);
			end
			`FBC_OP_SEC_EXIT: begin
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, `FBC_D_AUTOSEL, 1'b0);
				if (idx_q == 4'h3) cyc = wr(23'h00_0000, `FBC_D_ZERO, 1'b1);
			end
			`FBC_OP_PROGRAM: begin
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, `FBC_D_PROGRAM, 1'b0);
				if (idx_q == 4'h3) cyc = wr(addr_q, wdata_q, 1'b1);
			end
			`FBC_OP_BUF_START: begin
				// Count written is locations minus one, supplied by software
				if (idx_q == 4'h2) cyc = wr(addr_q, `FBC_D_BUF_LOAD, 1'b0);
				if (idx_q == 4'h3) cyc = wr(addr_q, wdata_q, 1'b1);
			end
			`FBC_OP_BUF_WORD: cyc = wr(addr_q, wdata_q, 1'b1);
			`FBC_OP_BUF_COMMIT: cyc = wr(addr_q, `FBC_D_BUF_COMMIT, 1'b1);
			`FBC_OP_ABORT_RST: begin
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, `FBC_D_RESET, 1'b1);
			end
			`FBC_OP_CHIP_ERASE, `FBC_OP_SECT_ERASE: begin
				// Unlock, 80, unlock again, then chip or sector code
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, `FBC_D_ERASE, 1'b0);
				if (idx_q == 4'h4) cyc = wr(`FBC_A_UNLOCK2, `FBC_D_UNLOCK2, 1'b0);
				if (idx_q == 4'h5) begin
					cyc = (op_q == `FBC_OP_CHIP_ERASE) ?
						wr(`FBC_A_UNLOCK1, `FBC_D_CHIP, 1'b1) :
						wr(addr_q, `FBC_D_SECTOR, 1'b1);
				end
			end
			`FBC_OP_BYP_ENTER: begin
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, `FBC_D_BYPASS, 1'b1);
			end
			`FBC_OP_BYP_PROG, `FBC_OP_PROT_PROG: begin
				// Two full cycles per item, also per password portion
				cyc = (idx_q == 4'h0) ? wr(23'h00_0000, `FBC_D_PROGRAM, 1'b0) :
					wr(addr_q, wdata_q, 1'b1);
			end
			`FBC_OP_BYP_RESET, `FBC_OP_PROT_EXIT: begin
				// 90 then 00 leaves bypass or protection mode
				cyc = (idx_q == 4'h0) ? wr(23'h00_0000, `FBC_D_AUTOSEL, 1'b0) :
					wr(23'h00_0000, `FBC_D_ZERO, 1'b1);
			end
			`FBC_OP_SUSPEND: cyc = wr(23'h00_0000, `FBC_D_SUSPEND, 1'b1);
			`FBC_OP_RESUME: cyc = wr(23'h00_0000, `FBC_D_RESUME, 1'b1);
			`FBC_OP_QUERY: cyc = wr(`FBC_A_QUERY, `FBC_D_QUERY, 1'b1);
			`FBC_OP_PROT_ENTER: begin
				if (idx_q == 4'h2) cyc = wr(`FBC_A_UNLOCK1, {8'h00, wdata_q[7:0]}, 1'b1);
			end
			`FBC_OP_PPB_ERASE: begin
				// Device pre-programs all bits itself before erasing
				cyc = (idx_q == 4'h0) ? wr(23'h00_0000, `FBC_D_ERASE, 1'b0) :
					wr(23'h00_0000, `FBC_D_SECTOR, 1'b1);
			end
			`FBC_OP_PWD_UNLOCK: begin
				// 25, count, four 16-bit portions at 00..03, then 29: seven cycles
				if (idx_q == 4'h0) cyc = wr(23'h00_0000, `FBC_D_BUF_LOAD, 1'b0);
				else if (idx_q == 4'h1) cyc = wr(23'h00_0000, `FBC_D_PWD_COUNT, 1'b0);
				else if (idx_q == 4'h6) cyc = wr(23'h00_0000, `FBC_D_BUF_COMMIT, 1'b1);
				else cyc = wr({21'h00_0000, 2'(idx_q - 4'h2)},
					pwd_q[16*(idx_q-4'h2) +: 16], 1'b0);
			end
			default: cyc = wr(23'h00_0000, `FBC_D_RESET, 1'b1);
		endcase
	end

	fbc_bus_cycle u_cycle (
		.clock(clock),
		.rst(rst),
		.start(launch_q),
		.cyc(cyc),
		.done(cyc_done),
		.rdata_q(sub_rdata_unused),
		.flash_addr(flash_addr),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe(flash_dq_oe),
		.flash_ce_n(flash_ce_n),
		.flash_we_n(flash_we_n),
		.flash_oe_n(flash_oe_n)
	);

	assign cmd_wr = reg_write && (reg_addr == `FBC_REG_CMD);
	assign new_op = reg_wdata[4:0];

	// Host keeps mode order itself; out-of-mode commands are refused, not sent
	always_comb begin
		unique case (new_op)
			`FBC_OP_PROT_PROG, `FBC_OP_PPB_ERASE, `FBC_OP_PWD_UNLOCK, `FBC_OP_PROT_READ,
			`FBC_OP_PROT_EXIT: allowed = prot_q;
			`FBC_OP_PROT_ENTER: allowed = !prot_q;
			`FBC_OP_BUF_WORD: allowed = buf_q && (buf_cyc_q < `FBC_BUF_MAX_CYC - 6'd1);
			`FBC_OP_BUF_COMMIT: allowed = buf_q;
			`FBC_OP_SUSPEND: allowed = erase_q && !susp_q;
			`FBC_OP_RESUME: allowed = susp_q;
			`FBC_OP_BYP_PROG, `FBC_OP_BYP_RESET: allowed = byp_q;
			default: allowed = (new_op <= `FBC_OP_PROT_READ);
		endcase
	end

	// Operation sequencer and mode tracking
	always_comb begin
		op_d = op_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		pwd_d = pwd_q;
		idx_d = idx_q;
		busy_d = busy_q;
		refused_d = refused_q;
		launch_d = 1'b0;
		prot_d = prot_q;
		byp_d = byp_q;
		buf_d = buf_q;
		erase_d = erase_q;
		susp_d = susp_q;
		prot_code_d = prot_code_q;
		buf_cyc_d = buf_cyc_q;
		rdata_d = rdata_q;
		if (reg_write && !busy_q) begin
			if (reg_addr == `FBC_REG_ADDR) addr_d = reg_wdata[22:0];
			if (reg_addr == `FBC_REG_WDATA) wdata_d = reg_wdata[15:0];
			if (reg_addr == `FBC_REG_PWD_LO) pwd_d[31:0] = reg_wdata;
			if (reg_addr == `FBC_REG_PWD_HI) pwd_d[63:32] = reg_wdata;
		end
		if (cmd_wr && !busy_q) begin
			refused_d = !allowed;
			if (allowed) begin
				op_d = new_op;
				idx_d = 4'h0;
				busy_d = 1'b1;
				launch_d = 1'b1;
			end
		end
		// Read data taken while output enable is still low; once the strobes rise
		// the device lets go of the bus and the pins no longer hold the value
		if (!flash_oe_n) rdata_d = flash_dq_in;
		if (cyc_done) begin
			if (cyc.last) begin
				busy_d = 1'b0;
				unique case (op_q)
					`FBC_OP_RESET, `FBC_OP_ABORT_RST: begin
						// Reset clears every tracked mode except protection mode
						byp_d = 1'b0;
						buf_d = 1'b0;
						erase_d = 1'b0;
						susp_d = 1'b0;
					end
					`FBC_OP_PROT_ENTER: begin
						prot_d = 1'b1;
						prot_code_d = wdata_q[7:0];
					end
					`FBC_OP_PROT_EXIT: prot_d = 1'b0;
					`FBC_OP_BYP_ENTER: byp_d = 1'b1;
					`FBC_OP_BYP_RESET: byp_d = 1'b0;
					`FBC_OP_BUF_START: begin
						buf_d = 1'b1;
						buf_cyc_d = 6'd4;
					end
					`FBC_OP_BUF_WORD: buf_cyc_d = buf_cyc_q + 6'd1;
					`FBC_OP_BUF_COMMIT: begin
						buf_d = 1'b0;
						buf_cyc_d = buf_cyc_q + 6'd1;
					end
					`FBC_OP_SECT_ERASE: erase_d = 1'b1;
					`FBC_OP_SUSPEND: susp_d = 1'b1;
					`FBC_OP_RESUME: susp_d = 1'b0;
					default: ;
				endcase
			end else begin
				idx_d = idx_q + 4'h1;
				launch_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			op_q <= `FBC_OP_READ;
			addr_q <= 23'h00_0000;
			wdata_q <= 16'h0000;
			pwd_q <= 64'h0000_0000_0000_0000;
			idx_q <= 4'h0;
			busy_q <= 1'b0;
			refused_q <= 1'b0;
			launch_q <= 1'b0;
			prot_q <= 1'b0;
			byp_q <= 1'b0;
			buf_q <= 1'b0;
			erase_q <= 1'b0;
			susp_q <= 1'b0;
			prot_code_q <= 8'h00;
			buf_cyc_q <= 6'd0;
			rdata_q <= 16'h0000;
		end else begin
			op_q <= op_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			pwd_q <= pwd_d;
			idx_q <= idx_d;
			busy_q <= busy_d;
			refused_q <= refused_d;
			launch_q <= launch_d;
			prot_q <= prot_d;
			byp_q <= byp_d;
			buf_q <= buf_d;
			erase_q <= erase_d;
			susp_q <= susp_d;
			prot_code_q <= prot_code_d;
			buf_cyc_q <= buf_cyc_d;
			rdata_q <= rdata_d;
		end
	end

	// Register read mux; data stand the cycle after the strobe
	always_comb begin
		reg_rdata_d = 32'h0000_0000;
		unique case (reg_addr)
			`FBC_REG_ADDR: reg_rdata_d = {9'h000, addr_q};
			`FBC_REG_WDATA: reg_rdata_d = {16'h0000, wdata_q};
			`FBC_REG_STATUS: begin
				reg_rdata_d = {24'h00_0000, !rdata_q[0], susp_q, erase_q, buf_q, byp_q,
					prot_q, refused_q, busy_q};
			end
			`FBC_REG_RDATA: reg_rdata_d = {16'h0000, rdata_q};
			default: reg_rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_read ? reg_rdata_d : 32'h0000_0000;
		end
	end

	assign flash_byte_n = 1'b0; // Byte-wide mode only
	// High while in persistent or dynamic protection mode
	assign accelerate_pin = prot_q &&
		(prot_code_q == 8'(`FBC_D_PPB_CODE) || prot_code_q == 8'(`FBC_D_DYB_CODE));

	AST_UNLOCK_FIRST: assert property (@(posedge clock) disable iff (rst)
		launch_q && idx_q == 4'h0 && op_q == `FBC_OP_PROGRAM |=>
		flash_addr == `FBC_A_UNLOCK1 && flash_dq_out == `FBC_D_UNLOCK1)
		else $error("first program cycle is not the unlock write");
	AST_RESET_CODE: assert property (@(posedge clock) disable iff (rst)
		launch_q && op_q == `FBC_OP_RESET |=> flash_dq_out == `FBC_D_RESET && flash_dq_oe)
		else $error("reset does not drive F0");
	AST_PROT_GATED: assert property (@(posedge clock) disable iff (rst)
		cmd_wr && !busy_q && new_op == `FBC_OP_PROT_PROG && !prot_q |=> refused_q && !busy_q)
		else $error("protection command accepted outside its mode");
	AST_ACCEL: assert property (@(posedge clock) disable iff (rst)
		!flash_we_n && prot_q && prot_code_q == 8'(`FBC_D_PPB_CODE) |-> accelerate_pin)
		else $error("accelerate pin low while setting protect bits");
	AST_ADDR_STABLE: assert property (@(posedge clock) disable iff (rst)
		$fell(flash_we_n) |-> $stable(flash_addr) ##1 $stable(flash_addr))
		else $error("address moved around the write strobe edge");
	AST_BUF_LIMIT: assert property (@(posedge clock) disable iff (rst)
		buf_cyc_q <= `FBC_BUF_MAX_CYC)
		else $error("buffer sequence exceeds its cycle limit");
	AST_SUSPEND_GATED: assert property (@(posedge clock) disable iff (rst)
		launch_q && op_q == `FBC_OP_SUSPEND |-> erase_q && !susp_q)
		else $error("suspend issued without sector erase");
	AST_RESUME_GATED: assert property (@(posedge clock) disable iff (rst)
		launch_q && op_q == `FBC_OP_RESUME |-> susp_q)
		else $error("resume issued while not suspended");
	AST_PWD_SEVEN: assert property (@(posedge clock) disable iff (rst)
		cmd_wr && !busy_q && allowed && new_op == `FBC_OP_PWD_UNLOCK |->
		##[1:80] (cyc_done && cyc.last && idx_q == 4'h6))
		else $error("password unlock did not end on its seventh cycle");

	COV_ERASE_SUSPEND: cover property (@(posedge clock) disable iff (rst)
		launch_q && op_q == `FBC_OP_SUSPEND);
	COV_BUF_COMMIT: cover property (@(posedge clock) disable iff (rst)
		cyc_done && op_q == `FBC_OP_BUF_COMMIT);
	COV_PROT_EXIT: cover property (@(posedge clock) disable iff (rst)
		cyc_done && cyc.last && op_q == `FBC_OP_PROT_EXIT);
endmodule

// file: rtl/fbc_pkg.sv
// Types shared by the flash bus controller
package fbc_pkg;
	// One flash bus cycle to perform
	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] data;
		logic rd;
		logic last;
	} fbc_cycle_s;

	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_SETUP,
		CYC_PULSE,
		CYC_HOLD
	} fbc_cyc_state_e;
endpackage
